// *** rtl/esc_consts.svh ***
// Purpose: numeric constants of the eye-scan control block
// Assumes: included by its bare name
// Notes: register indices; byte address is four times the index
`ifndef ESC_CONSTS_SVH
`define ESC_CONSTS_SVH
`define ESC_LANES 16
`define ESC_IDX_RUN 10'h1f0
`define ESC_IDX_CTRL 10'h1f1
`define ESC_IDX_PO 10'h1f2
`define ESC_IDX_VO 10'h1f3
`define ESC_IDX_BSEL 10'h1f4
`define ESC_IDX_CLR 10'h1f5
`define ESC_IDX_DONE 10'h1f6
`define ESC_IDX_ISTAT 10'h220
`define ESC_IDX_IMASK 10'h221
`define ESC_GRP_OUTC 6'h20
`define ESC_GRP_COUNT 6'h21
`define ESC_RESET_BYTE 8'h00
`define ESC_RUN_BIT 0
`define ESC_CLR_BIT 0
`define ESC_LEN_HI 5
`define ESC_LEN_LO 4
`define ESC_MODE_HI 3
`define ESC_MODE_LO 0
`define ESC_PO_HI 6
`define ESC_VO_HI 5
`define ESC_BSEL_HI 4
`define ESC_LEN0 16'd127
`define ESC_LEN1 16'd1032
`define ESC_LEN2 16'd8191
`define ESC_LEN3 16'd65535
`define ESC_SLOT_LAST 5'd19
`define ESC_COUNT_MAX 16'hffff
`define ESC_LEVEL_MAX 6'h1f
`define ESC_LEVEL_MIN 6'h20
`define ESC_IRQ_DONE 0
`define ESC_IRQ_SAT 1
`endif

// *** rtl/esc_pkg.sv ***
// Purpose: types shared by the eye-scan control modules
// Assumes: constants come from esc_consts.svh
// Notes: state codes follow a gray path idle, run, done
package esc_pkg;
  typedef enum logic [1:0] {ESC_IDLE = 2'b00, ESC_RUN = 2'b01, ESC_DONE = 2'b11} esc_state_type;
  typedef enum logic [3:0] {
    ESC_OFF = 4'h0, ESC_CMP = 4'h1, ESC_CMP0 = 4'h2, ESC_CMP1 = 4'h3, ESC_ONES = 4'h4,
    ESC_AVG0 = 4'h8, ESC_LOW0 = 4'h9, ESC_HIGH0 = 4'ha,
    ESC_AVG1 = 4'hc, ESC_HIGH1 = 4'hd, ESC_LOW1 = 4'he
  } esc_mode_type;
  typedef struct packed {
    esc_state_type state;
    logic [4:0] slot;
    logic [15:0] analyzed;
    logic [15:0] count;
    logic [5:0] level;
  } esc_lane_state_type;
  typedef struct packed {
    logic [7:0] run;
    logic [7:0] ctrl;
    logic [7:0] po;
    logic [7:0] vo;
    logic [7:0] bsel;
    logic [7:0] clr;
    logic ack;
    logic [31:0] rdata;
    logic [1:0] stat;
    logic [1:0] mask;
    logic run_prev;
    logic all_prev;
    logic sat_prev;
  } esc_top_state_type;
endpackage

// *** rtl/esc_lane_if.sv ***
// Purpose: settings to one lane engine and its results back
// Assumes: one instance per lane
// Notes: ctrl drives settings, lane drives results
`timescale 1ns/1ns
interface esc_lane_if;
  logic [3:0] mode;
  logic [15:0] target;
  logic [4:0] bitsel;
  logic [5:0] voffset;
  logic start;
  logic clear;
  logic done;
  logic sat;
  logic [15:0] count;
  logic [5:0] level;
  modport ctrl (output mode, target, bitsel, voffset, start, clear, input done, sat, count, level);
  modport lane (input mode, target, bitsel, voffset, start, clear, output done, sat, count, level);
endinterface

// *** rtl/esc_lane.sv ***
// Purpose: eye-scan engine of one receive lane
// Assumes: one sample_valid pulse per received bit
// Notes: count saturates; level is the threshold fed to the eye sampler
`timescale 1ns/1ns
`include "esc_consts.svh"
module esc_lane (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sample_valid,
  input wire logic normal_bit,
  input wire logic eye_bit,
  esc_lane_if.lane lif
);
  esc_pkg::esc_lane_state_type s_reg, s_next;
  logic zeros_only, ones_only, all_bits, search, take, up, down, hit;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    zeros_only = lif.mode inside {esc_pkg::ESC_CMP0, esc_pkg::ESC_AVG0, esc_pkg::ESC_LOW0, esc_pkg::ESC_HIGH0};
    ones_only = lif.mode inside {esc_pkg::ESC_CMP1, esc_pkg::ESC_AVG1, esc_pkg::ESC_LOW1, esc_pkg::ESC_HIGH1};
    all_bits = lif.mode inside {esc_pkg::ESC_CMP, esc_pkg::ESC_ONES};
    search = lif.mode inside {esc_pkg::ESC_AVG0, esc_pkg::ESC_LOW0, esc_pkg::ESC_HIGH0,
                              esc_pkg::ESC_AVG1, esc_pkg::ESC_LOW1, esc_pkg::ESC_HIGH1};
    take = sample_valid && (s_reg.slot == lif.bitsel) && (s_reg.state == esc_pkg::ESC_RUN)
           && (all_bits || (zeros_only && !normal_bit) || (ones_only && normal_bit));
    hit = ((lif.mode inside {esc_pkg::ESC_CMP, esc_pkg::ESC_CMP0, esc_pkg::ESC_CMP1}) && (eye_bit != normal_bit))
          || ((lif.mode == esc_pkg::ESC_ONES) && eye_bit);
    up = eye_bit && (lif.mode inside {esc_pkg::ESC_AVG0, esc_pkg::ESC_HIGH0, esc_pkg::ESC_AVG1, esc_pkg::ESC_HIGH1});
    down = !eye_bit && (lif.mode inside {esc_pkg::ESC_AVG0, esc_pkg::ESC_LOW0, esc_pkg::ESC_AVG1, esc_pkg::ESC_LOW1});
    s_next = s_reg;
    if (sample_valid)
    begin
      s_next.slot = (s_reg.slot == `ESC_SLOT_LAST) ? 5'h00 : s_reg.slot + 5'h01;
    end
    if (!search)
    begin
      s_next.level = lif.voffset;
    end
    if (lif.start)
    begin
      s_next.analyzed = 16'h0000;
      s_next.state = (all_bits || zeros_only || ones_only) ? esc_pkg::ESC_RUN : esc_pkg::ESC_DONE;
      if (search)
      begin
        s_next.level = 6'h00;
      end
    end
    else if (take)
    begin
      s_next.analyzed = s_reg.analyzed + 16'h0001;
      if (hit && s_reg.count != `ESC_COUNT_MAX)
      begin
        s_next.count = s_reg.count + 16'h0001;
      end
      if (up && s_reg.level != `ESC_LEVEL_MAX)
      begin
        s_next.level = s_reg.level + 6'h01;
      end
      else if (down && s_reg.level != `ESC_LEVEL_MIN)
      begin
        s_next.level = s_reg.level - 6'h01;
      end
      if (s_next.analyzed == lif.target)
      begin
        s_next.state = esc_pkg::ESC_DONE;
      end
    end
    if (lif.clear)
    begin
      s_next.count = 16'h0000;
    end
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  // results
  // done flag per lane
  assign lif.done = (s_reg.state == esc_pkg::ESC_DONE);
  assign lif.sat = (s_reg.count == `ESC_COUNT_MAX);
  assign lif.count = s_reg.count;
  assign lif.level = s_reg.level;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_done_at_length: assert property ((take && !lif.start && s_reg.analyzed + 16'h0001 == lif.target)
    |=> s_reg.state == esc_pkg::ESC_DONE) else $error("lane did not finish at length");
  a_slot_in_range: assert property (s_reg.slot <= `ESC_SLOT_LAST) else $error("slot out of range");
  a_result_held: assert property ((s_reg.state == esc_pkg::ESC_DONE && search && !lif.start) |=> $stable(s_reg.level))
    else $error("search result moved after done");
  a_run_from_start: assert property ($rose(s_reg.state == esc_pkg::ESC_RUN) |-> $past(lif.start))
    else $error("scan ran without start");
  a_counter_cleared: assert property (lif.clear |=> s_reg.count == 16'h0000)
    else $error("count not cleared");
  c_lane_done: cover property (s_reg.state == esc_pkg::ESC_RUN ##1 s_reg.state == esc_pkg::ESC_DONE);
endmodule

// *** rtl/esc_top.sv ***
// Purpose: eye-scan control with Avalon-MM register access
// Assumes: lane sample inputs synchronous to CLK
// Notes: one wait cycle per bus access
`timescale 1ns/1ns
`include "esc_consts.svh"
module esc_top (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [11:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic [`ESC_LANES-1:0] LANE_VALID,
  input wire logic [`ESC_LANES-1:0] LANE_NORMAL,
  input wire logic [`ESC_LANES-1:0] LANE_EYE,
  output logic [6:0] PHASE_OFFSET,
  output logic [6*`ESC_LANES-1:0] LANE_VOFFSET,
  output logic IRQ
);
  esc_pkg::esc_top_state_type s_reg, s_next;
  logic [`ESC_LANES-1:0] done_w;
  logic [`ESC_LANES-1:0] sat_w;
  logic [15:0] count_w [`ESC_LANES];
  logic [5:0] level_w [`ESC_LANES];
  logic [9:0] idx;
  logic req, start, all_done, any_sat, wr_take, rd_take;
  logic [1:0] stat_evt;
  logic [15:0] target;

  // ------------------------------------------------------------
  // decode and scan settings
  // ------------------------------------------------------------
  assign idx = AVS_ADDRESS[11:2];
  assign req = AVS_READ || AVS_WRITE;
  assign wr_take = s_reg.ack && AVS_WRITE;
  assign rd_take = s_reg.ack && AVS_READ;
  assign start = s_reg.run[`ESC_RUN_BIT] && !s_reg.run_prev;
  assign all_done = &done_w;
  assign any_sat = |sat_w;
  // status events that land at this edge
  assign stat_evt = {any_sat && !s_reg.sat_prev, all_done && !s_reg.all_prev};

  // length code to sample count
  // length table
  always_comb
  begin
    case (s_reg.ctrl[`ESC_LEN_HI:`ESC_LEN_LO])
      2'b00: target = `ESC_LEN0;
      2'b01: target = `ESC_LEN1;
      2'b10: target = `ESC_LEN2;
      2'b11: target = `ESC_LEN3;
      default: target = `ESC_LEN0;
    endcase
  end

  // ------------------------------------------------------------
  // lane engines
  // ------------------------------------------------------------
  for (genvar g = 0; g < `ESC_LANES; g++)
  begin : g_lane
    esc_lane_if lif ();
    assign lif.mode = s_reg.ctrl[`ESC_MODE_HI:`ESC_MODE_LO];
    assign lif.target = target;
    assign lif.bitsel = s_reg.bsel[`ESC_BSEL_HI:0];
    assign lif.voffset = s_reg.vo[`ESC_VO_HI:0];
    assign lif.start = start;
    assign lif.clear = s_reg.clr[`ESC_CLR_BIT];
    assign done_w[g] = lif.done;
    assign sat_w[g] = lif.sat;
    assign count_w[g] = lif.count;
    assign level_w[g] = lif.level;
    assign LANE_VOFFSET[6*g +: 6] = lif.level;
    esc_lane u_lane (
      .clk(CLK),
      .rst_n(RST_N),
      .sample_valid(LANE_VALID[g]),
      .normal_bit(LANE_NORMAL[g]),
      .eye_bit(LANE_EYE[g]),
      .lif(lif)
    );
  end

  // ------------------------------------------------------------
  // register file and bus slave
  // ------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    // one wait cycle, then complete
    s_next.ack = req && !s_reg.ack;
    s_next.run_prev = s_reg.run[`ESC_RUN_BIT];
    s_next.all_prev = all_done;
    s_next.sat_prev = any_sat;
    // read data staged during the wait cycle
    if (req && !s_reg.ack)
    begin
      case (idx)
        `ESC_IDX_RUN: s_next.rdata = {24'h000000, s_reg.run};
        `ESC_IDX_CTRL: s_next.rdata = {24'h000000, s_reg.ctrl};
        `ESC_IDX_PO: s_next.rdata = {24'h000000, s_reg.po};
        `ESC_IDX_VO: s_next.rdata = {24'h000000, s_reg.vo};
        `ESC_IDX_BSEL: s_next.rdata = {24'h000000, s_reg.bsel};
        `ESC_IDX_CLR: s_next.rdata = {24'h000000, s_reg.clr};
        `ESC_IDX_DONE: s_next.rdata = {16'h0000, done_w};
        // staged word includes events of this edge, so the later clear drops none unseen
        `ESC_IDX_ISTAT: s_next.rdata = {30'h00000000, s_reg.stat | stat_evt};
        `ESC_IDX_IMASK: s_next.rdata = {30'h00000000, s_reg.mask};
        default:
        begin
          if (idx[9:4] == `ESC_GRP_OUTC)
            s_next.rdata = {26'h0000000, level_w[idx[3:0]]};
          else if (idx[9:4] == `ESC_GRP_COUNT)
            s_next.rdata = {16'h0000, count_w[idx[3:0]]};
          else
            s_next.rdata = 32'h00000000;
        end
      endcase
    end
    // writes land at the completing edge
    if (wr_take && AVS_BYTEENABLE[0])
    begin
      case (idx)
        `ESC_IDX_RUN: s_next.run = AVS_WRITEDATA[7:0];
        `ESC_IDX_CTRL: s_next.ctrl = AVS_WRITEDATA[7:0];
        `ESC_IDX_PO: s_next.po = AVS_WRITEDATA[7:0];
        `ESC_IDX_VO: s_next.vo = AVS_WRITEDATA[7:0];
        `ESC_IDX_BSEL: s_next.bsel = AVS_WRITEDATA[7:0];
        `ESC_IDX_CLR: s_next.clr = AVS_WRITEDATA[7:0];
        `ESC_IDX_IMASK: s_next.mask = AVS_WRITEDATA[1:0];
        default: s_next.mask = s_reg.mask;
      endcase
    end
    // status clears on read, new events win
    if (rd_take && idx == `ESC_IDX_ISTAT)
    begin
      s_next.stat = 2'b00;
    end
    if (all_done && !s_reg.all_prev)
    begin
      s_next.stat[`ESC_IRQ_DONE] = 1'b1;
    end
    if (any_sat && !s_reg.sat_prev)
    begin
      s_next.stat[`ESC_IRQ_SAT] = 1'b1;
    end
  end

  // state register
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  // outputs
  assign AVS_WAITREQUEST = req && !s_reg.ack;
  assign AVS_READDATA = s_reg.rdata;
  assign PHASE_OFFSET = s_reg.po[`ESC_PO_HI:0];
  assign IRQ = |(s_reg.stat & s_reg.mask);

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  a_bus_one_wait: assert property ($rose(AVS_READ) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
    else $error("read not answered after one wait");
  a_run_starts_scan: assert property ((start && s_reg.ctrl[`ESC_MODE_HI:`ESC_MODE_LO] == esc_pkg::ESC_CMP)
    |=> done_w == '0) else $error("start did not clear done flags");
  a_run_write_start: assert property ((wr_take && AVS_BYTEENABLE[0] && idx == `ESC_IDX_RUN && AVS_WRITEDATA[0]
    && !s_reg.run[`ESC_RUN_BIT]) |=> start) else $error("run write did not start scan");
  a_phase_write: assert property ((wr_take && AVS_BYTEENABLE[0] && idx == `ESC_IDX_PO)
    |=> PHASE_OFFSET == $past(AVS_WRITEDATA[6:0])) else $error("phase offset not applied");
  a_done_irq: assert property (($rose(all_done) && s_reg.mask[`ESC_IRQ_DONE]) |=> IRQ)
    else $error("completion did not raise interrupt");
  a_stat_read_clear: assert property ((rd_take && idx == `ESC_IDX_ISTAT && !(all_done && !s_reg.all_prev)
    && !(any_sat && !s_reg.sat_prev)) |=> s_reg.stat == 2'b00) else $error("status not cleared by read");
  c_scan_done: cover property (start ##[1:1000] $rose(all_done));
  c_irq: cover property ($rose(IRQ));
  c_write_read: cover property (wr_take ##[1:4] rd_take);
endmodule

// *** testbench/esc_top_tb_top.sv ***
// Purpose: self-checking bench for esc_top
// Assumes: waitrequest answers every access
// Notes: lane bits go in groups of 20 pulses, so one sample per group counts
`timescale 1ns/1ns
`include "esc_consts.svh"
module esc_top_tb_top;
  // ----------------------------------------
  // signals and design
  // ----------------------------------------
  logic CLK, RST_N, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, IRQ;
  logic [11:0] AVS_ADDRESS;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, rd_data;
  logic [3:0] AVS_BYTEENABLE;
  logic [15:0] LANE_VALID, LANE_NORMAL, LANE_EYE;
  logic [6:0] PHASE_OFFSET;
  logic [95:0] LANE_VOFFSET;
  int miscompares, n_checks;
  int tgt [2] = '{127, 1032};
  logic [31:0] m_done [4] = '{32'hffff, 32'h0, 32'h0, 32'hffff};
  logic [31:0] m_cnt [4] = '{32'd100, 32'd90, 32'd10, 32'd90};
  logic [3:0] s_mode [6] = '{4'h8, 4'h9, 4'ha, 4'hc, 4'hd, 4'he};
  logic [5:0] s_exp [6] = '{6'h04, 6'h25, 6'h1f, 6'h04, 6'h1f, 6'h25};
  logic [3:0] off_mode [4] = '{4'h0, 4'h5, 4'hb, 4'hf};

  // clock source
  initial
  begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end

  esc_top uut (.CLK(CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .LANE_VALID(LANE_VALID),
    .LANE_NORMAL(LANE_NORMAL), .LANE_EYE(LANE_EYE), .PHASE_OFFSET(PHASE_OFFSET),
    .LANE_VOFFSET(LANE_VOFFSET), .IRQ(IRQ));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_pin(input string what, input logic [95:0] exp, input logic [95:0] got);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one bus access, held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [9:0] idx, input logic [7:0] d);
    AVS_ADDRESS <= {idx, 2'b00};
    AVS_WRITEDATA <= {24'h000000, d};
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0);
    rd_data = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    // idle edge so a following call never re-drives the strobe in the same step
    @(posedge CLK);
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask

  task automatic rdc(input string what, input logic [9:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 8'h00);
    chk_reg(what, exp, rd_data);
  endtask

  // all lanes get the same bit pair for 20 pulses per group
  task automatic send(input int groups, input logic nb, input logic eb);
    LANE_NORMAL <= {16{nb}};
    LANE_EYE <= {16{eb}};
    repeat (groups * 20)
    begin
      LANE_VALID <= 16'hffff;
      @(posedge CLK);
    end
    LANE_VALID <= 16'h0000;
    @(posedge CLK);
    @(posedge CLK);
  endtask

  // settings change only with run low, then a rising run bit
  // settings written with run low
  task automatic start(input logic [7:0] ctrl);
    wr(`ESC_IDX_RUN, 8'h00);
    wr(`ESC_IDX_CLR, 8'h01);
    wr(`ESC_IDX_CLR, 8'h00);
    wr(`ESC_IDX_CTRL, ctrl);
    wr(`ESC_IDX_RUN, 8'h01);
  endtask

  task automatic test_done;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // hang guard, 80000 cycles, about 1.3 times the expected run
  initial
  begin
    #1600000;
    miscompares++;
    test_done();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    miscompares = 0;
    n_checks = 0;
    RST_N = 1'b0;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_ADDRESS = 12'h000;
    AVS_WRITEDATA = 32'h0;
    AVS_BYTEENABLE = 4'hf;
    LANE_VALID = 16'h0;
    LANE_NORMAL = 16'h0;
    LANE_EYE = 16'h0;
    repeat (3) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    // reset values of the first five setting registers, run to bsel
    for (int i = 0; i < 5; i++)
      rdc("reset value", `ESC_IDX_RUN + 10'(i), 32'h0);
    wr(`ESC_IDX_PO, 8'h40);
    wr(`ESC_IDX_VO, 8'h05);
    wr(`ESC_IDX_BSEL, 8'h13);
    AVS_BYTEENABLE <= 4'h0;
    wr(`ESC_IDX_PO, 8'h11);
    AVS_BYTEENABLE <= 4'hf;
    rdc("phase reg", `ESC_IDX_PO, 32'h40);
    rdc("slot select", `ESC_IDX_BSEL, 32'h13);
    rdc("unmapped", 10'h100, 32'h0);
    chk_pin("phase pins", 96'h40, 96'(PHASE_OFFSET));
    chk_pin("threshold pins", {16{6'h05}}, LANE_VOFFSET);
    for (int l = 0; l < 2; l++)
    begin
      start({2'b00, 2'(l), 4'h1});
      rdc("done at start", `ESC_IDX_DONE, 32'h0);
      send(27, 1'b0, 1'b1);
      send(tgt[l] - 28, 1'b0, 1'b0);
      rdc("done early", `ESC_IDX_DONE, 32'h0);
      send(1, 1'b0, 1'b0);
      rdc("done", `ESC_IDX_DONE, 32'hffff);
      rdc("count", {`ESC_GRP_COUNT, 4'hf}, 32'd27);
      if (l == 0)
      begin
        chk_pin("irq masked", 96'h0, 96'(IRQ));
        wr(`ESC_IDX_IMASK, 8'h01);
        chk_pin("irq", 96'h1, 96'(IRQ));
        rdc("status", `ESC_IDX_ISTAT, 32'h1);
        chk_pin("irq cleared", 96'h0, 96'(IRQ));
        rdc("status again", `ESC_IDX_ISTAT, 32'h0);
      end
    end
    for (int m = 0; m < 4; m++)
    begin
      start({4'h0, 4'(m + 1)});
      rdc("cleared count", {`ESC_GRP_COUNT, 4'h0}, 32'h0);
      send(10, 1'b1, 1'b0);
      send(27, 1'b0, 1'b0);
      send(90, 1'b0, 1'b1);
      rdc("mode done", `ESC_IDX_DONE, m_done[m]);
      send(10, 1'b0, 1'b0);
      send(117, 1'b1, 1'b1);
      rdc("mode count", {`ESC_GRP_COUNT, 4'h0}, m_cnt[m]);
      rdc("kept offset", {`ESC_GRP_OUTC, 4'h0}, 32'h05);
    end
    for (int s = 0; s < 6; s++)
    begin
      start({4'h0, s_mode[s]});
      send(5, s < 3, 1'b0);
      send(100, s >= 3, 1'b1);
      send(27, s >= 3, 1'b0);
      rdc("found level", {`ESC_GRP_OUTC, 4'hf}, {26'h0, s_exp[s]});
    end
    for (int i = 0; i < 4; i++)
    begin
      start({4'h0, off_mode[i]});
      rdc("off done", `ESC_IDX_DONE, 32'hffff);
      send(2, 1'b0, 1'b1);
      rdc("off count", {`ESC_GRP_COUNT, 4'h0}, 32'h0);
    end
    test_done();
  end
endmodule
